// [acs_pkg.sv]
package acs_pkg;

  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] OFF_CTRL_A      = 8'h00;
  localparam logic [7:0] OFF_CTRL_B      = 8'h04;
  localparam logic [7:0] OFF_INPUT_SEL   = 8'h08;
  localparam logic [7:0] OFF_RESULT_LOW  = 8'h0C;
  localparam logic [7:0] OFF_RESULT_HIGH = 8'h10;
  localparam logic [7:0] OFF_STATUS      = 8'h14;

  // converter_ctrl_a fields
  localparam int CA_EN      = 0;
  localparam int CA_GO      = 1;
  localparam int CA_AUTO    = 2;
  localparam int CA_DONE    = 3;
  localparam int CA_DIV_LSB = 4;

  // converter_ctrl_b fields
  localparam int CB_TRIG_LSB = 0;
  localparam int CB_PGATE    = 3;

  // input_select_reg fields
  localparam int IS_CHAN_LSB = 0;
  localparam int IS_REF_LSB  = 4;

  // Status register fields
  localparam int ST_BUSY    = 0;
  localparam int ST_FIRST   = 1;
  localparam int ST_ACT_LSB = 2;
  localparam int ST_LOCK    = 8;

  // Reset values
  localparam logic [2:0] DIV_SEL_RST   = 3'h0;
  localparam logic [2:0] TRIG_SEL_RST  = 3'h0;
  localparam logic       PGATE_RST     = 1'b1;
  localparam logic [5:0] INPUT_SEL_RST = 6'h00;

  // Conversion timing in converter clock cycles and half cycles
  localparam int         CYC_NORMAL      = 13;
  localparam int         CYC_FIRST       = 25;
  localparam logic [5:0] LEN_NORMAL_HALF = 6'(2 * CYC_NORMAL);
  localparam logic [5:0] LEN_FIRST_HALF  = 6'(2 * CYC_FIRST);
  localparam logic [5:0] LEN_AUTO_HALF   = 6'h1B;
  localparam logic [5:0] SH_NORMAL_HALF  = 6'h03;
  localparam logic [5:0] SH_FIRST_HALF   = 6'h1B;
  localparam logic [5:0] SH_AUTO_HALF    = 6'h04;

  // Trigger source that means free running
  localparam logic [2:0] TRIG_FREE_RUN = 3'h0;
  localparam int         PRESC_W       = 7;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ACS_IDLE = 3'h1,
    ACS_WAIT = 3'h2,
    ACS_CONV = 3'h4
  } acs_state_e;

endpackage

// [acs_prescaler.sv]
`timescale 1ns/1ps
module acs_prescaler (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  // Control
  input  wire logic       enable,
  input  wire logic       restart,
  input  wire logic [2:0] div_sel,
  // Converter clock edges
  output logic            rise,
  output logic            fall
);

  typedef struct packed {
    logic [acs_pkg::PRESC_W-1:0] cnt;
  } acs_presc_s;

  acs_presc_s                  s_q;
  acs_presc_s                  s_d;
  logic [2:0]                  k;
  logic [acs_pkg::PRESC_W-1:0] mask;

  // One counter feeds every ratio, so edges never glitch on a change
  always_comb begin
    s_d  = s_q;
    k    = (div_sel == 3'h0) ? 3'h1 : div_sel;
    mask = 7'((8'h01 << k) - 8'h01);
    rise = enable && ((s_q.cnt & mask) == mask);
    fall = enable && ((s_q.cnt & mask) == (mask >> 1));
    if (!enable || restart) begin
      s_d.cnt = '0;
    end else begin
      s_d.cnt = s_q.cnt + 7'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  a_hold_off: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && !enable) |=> (s_q.cnt == '0) && !rise)
    else $error("prescaler not held while disabled");

endmodule

// [acs_sequencer.sv]
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
// Contract
// - conversion_go reads one during a conversion, hardware clears it after.
// - Channel change mid-conversion applies only after the running one ends.
// - Auto mode: selected trigger rising edge resets prescaler and starts one.
// - Trigger high at completion or edges during a conversion start nothing.
// - Trigger flag sets regardless; software clears it before next trigger.
// - Completion flag still set when a blocked result is discarded.
// - Done flag as source restarts at each completion; go starts the first.
// - Go write starts a single even in auto mode; go reads busy.
// - Prescaler runs while enabled and is held in reset while disabled.
// - Go-started conversion begins at next rising converter clock edge.
// - Normal conversion lasts 13 converter cycles, the first after enable 25.
// - Sample-hold 1.5 cycles after start, 13.5 for the first conversion.
// - Completion writes result, sets done flag, clears go in single mode.
// - Auto conversions sample two cycles after trigger, three sync clocks.
// - Free running restarts right after completion with go held high.
// - Selections buffered, locked at start, reopened in last converter cycle.
// - Free running: change after first completion hits the conversion after.
// - Reading result_low blocks updates until result_high is read.
// - Selections take effect only while the converter is enabled.
module acs_sequencer (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // AXI4-Lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Trigger sources, asynchronous
  input  wire logic [7:0]  trigger_in,
  // Analog core
  input  wire logic [9:0]  result_in,
  output logic             adc_clk,
  output logic             analog_enable,
  output logic [3:0]       channel_sel,
  output logic [1:0]       reference_sel,
  output logic             sample_hold,
  output logic             conv_active
);

  typedef struct packed {
    acs_pkg::acs_state_e state;
    logic                en;
    logic                auto_on;
    logic                done_flag;
    logic [2:0]          div_sel;
    logic [2:0]          trig_sel;
    logic                pgate;
    logic [5:0]          temp_sel;
    logic [5:0]          act_sel;
    logic                first;
    logic [5:0]          half_cnt;
    logic [5:0]          len_half;
    logic [5:0]          sh_half;
    logic [9:0]          result;
    logic                res_lock;
    logic [7:0]          sy1;
    logic [7:0]          sy2;
    logic [7:0]          sy3;
    logic [7:0]          trig_lvl;
    logic                adc_clk;
    logic                an_en;
    logic                sh;
    logic                active;
    logic                aw_full;
    logic [7:0]          aw_addr;
    logic                w_full;
    logic [7:0]          wdata;
    logic                wstrb0;
    logic                awready;
    logic                wready;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                arready;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
  } acs_seq_s;

  acs_seq_s   s_q;
  acs_seq_s   s_d;
  logic       en_eff;
  logic       unlocked;
  logic       go_wr;
  logic       sel_edge;
  logic       start_auto;
  logic       fin;
  logic       free_run;
  logic       p_rise;
  logic       p_fall;
  logic [7:0] lvl_new;
  logic [7:0] edges;

  acs_prescaler u_presc (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .enable  (en_eff),
    .restart (start_auto),
    .div_sel (s_q.div_sel),
    .rise    (p_rise),
    .fall    (p_fall)
  );

  always_comb begin
    s_d        = s_q;
    go_wr      = 1'b0;
    start_auto = 1'b0;
    fin        = 1'b0;
    en_eff     = s_q.en && !s_q.pgate;
    free_run   = s_q.auto_on && (s_q.trig_sel == acs_pkg::TRIG_FREE_RUN);
    // Change counts once second and third stages agree; adds 3 clocks
    s_d.sy1    = trigger_in;
    s_d.sy2    = s_q.sy1;
    s_d.sy3    = s_q.sy2;
    lvl_new    = (s_q.sy2 & ~(s_q.sy2 ^ s_q.sy3))
               | (s_q.trig_lvl & (s_q.sy2 ^ s_q.sy3));
    s_d.trig_lvl = lvl_new;
    edges      = lvl_new & ~s_q.trig_lvl;
    sel_edge   = !free_run && edges[s_q.trig_sel];
    s_d.sh     = 1'b0;

    // Write channel: address and data taken in either order
    if (s_axi_awvalid && s_q.awready) begin
      s_d.aw_full = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.w_full = 1'b1;
      s_d.wdata  = s_axi_wdata[7:0];
      s_d.wstrb0 = s_axi_wstrb[0];
    end
    if (s_q.aw_full && s_q.w_full && !s_q.bvalid) begin
      s_d.aw_full = 1'b0;
      s_d.w_full  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = acs_pkg::RESP_OKAY;
      if (s_q.aw_addr == acs_pkg::OFF_CTRL_A) begin
        if (s_q.wstrb0) begin
          s_d.en      = s_q.wdata[acs_pkg::CA_EN];
          s_d.auto_on = s_q.wdata[acs_pkg::CA_AUTO];
          s_d.div_sel = s_q.wdata[acs_pkg::CA_DIV_LSB +: 3];
          go_wr       = s_q.wdata[acs_pkg::CA_GO];
          if (s_q.wdata[acs_pkg::CA_DONE]) begin
            s_d.done_flag = 1'b0;
          end
        end
      end else if (s_q.aw_addr == acs_pkg::OFF_CTRL_B) begin
        if (s_q.wstrb0) begin
          s_d.trig_sel = s_q.wdata[acs_pkg::CB_TRIG_LSB +: 3];
          s_d.pgate    = s_q.wdata[acs_pkg::CB_PGATE];
        end
      end else if (s_q.aw_addr == acs_pkg::OFF_INPUT_SEL) begin
        if (s_q.wstrb0) begin
          s_d.temp_sel = s_q.wdata[5:0];
        end
      end else if (s_q.aw_addr == acs_pkg::OFF_RESULT_LOW ||
                   s_q.aw_addr == acs_pkg::OFF_RESULT_HIGH ||
                   s_q.aw_addr == acs_pkg::OFF_STATUS) begin
        s_d.bresp = acs_pkg::RESP_OKAY;
      end else begin
        s_d.bresp = acs_pkg::RESP_SLVERR;
      end
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end

    // Read channel; result_low read blocks result updates
    if (s_axi_arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = 32'h0000_0000;
      s_d.rresp  = acs_pkg::RESP_OKAY;
      if (s_axi_araddr == acs_pkg::OFF_CTRL_A) begin
        s_d.rdata[acs_pkg::CA_EN]          = s_q.en;
        s_d.rdata[acs_pkg::CA_GO]          =
          s_q.state != acs_pkg::ACS_IDLE;
        s_d.rdata[acs_pkg::CA_AUTO]        = s_q.auto_on;
        s_d.rdata[acs_pkg::CA_DONE]        = s_q.done_flag;
        s_d.rdata[acs_pkg::CA_DIV_LSB +: 3] = s_q.div_sel;
      end else if (s_axi_araddr == acs_pkg::OFF_CTRL_B) begin
        s_d.rdata[acs_pkg::CB_TRIG_LSB +: 3] = s_q.trig_sel;
        s_d.rdata[acs_pkg::CB_PGATE]         = s_q.pgate;
      end else if (s_axi_araddr == acs_pkg::OFF_INPUT_SEL) begin
        s_d.rdata[5:0] = s_q.temp_sel;
      end else if (s_axi_araddr == acs_pkg::OFF_RESULT_LOW) begin
        s_d.rdata[7:0] = s_q.result[7:0];
        s_d.res_lock   = 1'b1;
      end else if (s_axi_araddr == acs_pkg::OFF_RESULT_HIGH) begin
        s_d.rdata[1:0] = s_q.result[9:8];
        s_d.res_lock   = 1'b0;
      end else if (s_axi_araddr == acs_pkg::OFF_STATUS) begin
        s_d.rdata[acs_pkg::ST_BUSY]         = s_q.active;
        s_d.rdata[acs_pkg::ST_FIRST]        = s_q.first;
        s_d.rdata[acs_pkg::ST_ACT_LSB +: 6] = s_q.act_sel;
        s_d.rdata[acs_pkg::ST_LOCK]         = s_q.res_lock;
      end else begin
        s_d.rresp = acs_pkg::RESP_SLVERR;
      end
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end

    // Selection buffer reopens in the last converter cycle
    unlocked = (s_q.state != acs_pkg::ACS_CONV) ||
               (s_q.half_cnt >= (s_q.len_half - 6'h02));
    if (en_eff && unlocked) begin
      s_d.act_sel = s_q.temp_sel;
    end

    case (s_q.state)
      acs_pkg::ACS_IDLE: begin
        if (en_eff && s_q.auto_on && sel_edge) begin
          start_auto   = 1'b1;
          s_d.state    = acs_pkg::ACS_CONV;
          s_d.half_cnt = 6'h00;
          s_d.len_half = s_q.first ? acs_pkg::LEN_FIRST_HALF
                                   : acs_pkg::LEN_AUTO_HALF;
          s_d.sh_half  = s_q.first ? acs_pkg::SH_FIRST_HALF
                                   : acs_pkg::SH_AUTO_HALF;
          s_d.first    = 1'b0;
        end else if (en_eff && go_wr) begin
          s_d.state = acs_pkg::ACS_WAIT;
        end
      end
      acs_pkg::ACS_WAIT: begin
        if (p_rise) begin
          s_d.state    = acs_pkg::ACS_CONV;
          s_d.half_cnt = 6'h00;
          s_d.len_half = s_q.first ? acs_pkg::LEN_FIRST_HALF
                                   : acs_pkg::LEN_NORMAL_HALF;
          s_d.sh_half  = s_q.first ? acs_pkg::SH_FIRST_HALF
                                   : acs_pkg::SH_NORMAL_HALF;
          s_d.first    = 1'b0;
        end
      end
      acs_pkg::ACS_CONV: begin
        // Trigger edges here are dropped on purpose
        if (p_rise || p_fall) begin
          s_d.half_cnt = s_q.half_cnt + 6'h01;
          s_d.sh       = (s_d.half_cnt == s_q.sh_half);
          if (s_d.half_cnt == s_q.len_half) begin
            fin           = 1'b1;
            s_d.done_flag = 1'b1;
            if (!s_q.res_lock) begin
              s_d.result = result_in;
            end
            if (free_run) begin
              s_d.half_cnt = 6'h00;
              s_d.len_half = acs_pkg::LEN_NORMAL_HALF;
              s_d.sh_half  = acs_pkg::SH_NORMAL_HALF;
            end else begin
              s_d.state = acs_pkg::ACS_IDLE;
            end
          end
        end
      end
      default: begin
        s_d.state = acs_pkg::ACS_IDLE;
      end
    endcase

    // Disable aborts and rearms the long first conversion
    if (!en_eff) begin
      s_d.state = acs_pkg::ACS_IDLE;
      s_d.first = 1'b1;
    end
    if (p_rise) begin
      s_d.adc_clk = 1'b1;
    end else if (p_fall || !en_eff) begin
      s_d.adc_clk = 1'b0;
    end
    s_d.an_en   = en_eff;
    s_d.active  = (s_d.state == acs_pkg::ACS_CONV);
    s_d.awready = !s_d.aw_full && !s_d.bvalid;
    s_d.wready  = !s_d.w_full && !s_d.bvalid;
    s_d.arready = !s_d.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q          <= '0;
      s_q.state    <= acs_pkg::ACS_IDLE;
      s_q.first    <= 1'b1;
      s_q.div_sel  <= acs_pkg::DIV_SEL_RST;
      s_q.trig_sel <= acs_pkg::TRIG_SEL_RST;
      s_q.pgate    <= acs_pkg::PGATE_RST;
      s_q.temp_sel <= acs_pkg::INPUT_SEL_RST;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready  = s_q.wready;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;
  assign adc_clk       = s_q.adc_clk;
  assign analog_enable = s_q.an_en;
  assign channel_sel   = s_q.act_sel[3:0];
  assign reference_sel = s_q.act_sel[5:4];
  assign sample_hold   = s_q.sh;
  assign conv_active   = s_q.active;

  a_single_done: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && fin && !free_run && en_eff) |=>
      (s_q.done_flag && s_q.state == acs_pkg::ACS_IDLE && !s_q.active))
    else $error("single completion did not clear go and set flag");

  a_done_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && fin && s_q.res_lock) |=> (s_q.done_flag && $stable(s_q.result)))
    else $error("blocked completion lost flag or changed result");

  a_sel_locked: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && s_q.state == acs_pkg::ACS_CONV &&
     s_q.half_cnt < s_q.len_half - 6'h02) |=> $stable(s_q.act_sel))
    else $error("selection changed while locked");

  a_go_on_rise: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && en_eff && s_q.state == acs_pkg::ACS_WAIT && p_rise) |=>
      (s_q.active && s_q.half_cnt == 6'h00))
    else $error("go request did not start at converter edge");

  a_len_match: assert property (@(posedge aclk) disable iff (!aresetn)
    fin |-> (s_q.len_half == acs_pkg::LEN_NORMAL_HALF ||
             s_q.len_half == acs_pkg::LEN_FIRST_HALF ||
             s_q.len_half == acs_pkg::LEN_AUTO_HALF) &&
            (s_q.half_cnt == s_q.len_half - 6'h01))
    else $error("conversion ended at wrong length");

  a_sh_point: assert property (@(posedge aclk) disable iff (!aresetn)
    (sample_hold && s_q.active) |-> (s_q.half_cnt == s_q.sh_half))
    else $error("sample-hold at wrong half cycle");

  a_edge_ignore: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && en_eff && s_q.state == acs_pkg::ACS_CONV && !fin && sel_edge)
      |=> (s_q.state == acs_pkg::ACS_CONV &&
           s_q.half_cnt >= $past(s_q.half_cnt)))
    else $error("trigger edge disturbed running conversion");

  a_free_run: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && en_eff && fin && free_run) |=>
      (s_q.active && s_q.half_cnt == 6'h00 && s_q.done_flag))
    else $error("free running did not restart");

  a_auto_start: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && start_auto) |=> (s_q.active && !p_rise && s_q.half_cnt == 6'h00))
    else $error("auto trigger did not restart prescaler and start");

endmodule

// [acs_analog_model.sv]
`timescale 1ns/1ps
module acs_analog_model (
  // Clock
  input  wire logic       aclk,
  // Converter side
  input  wire logic       analog_enable,
  input  wire logic [3:0] channel_sel,
  input  wire logic [1:0] reference_sel,
  input  wire logic       sample_hold,
  output logic [9:0]      result_in,
  // Trigger levels asked for by the bench
  input  wire logic [7:0] trig_lvl,
  output logic [7:0]      trigger_in
);
  logic [9:0] held_q = 10'h155;

  // Code carries the selections, so a stale channel shows in the result
  always @(posedge aclk) begin
    if (!analog_enable) begin
      held_q <= ~held_q;
    end else if (sample_hold) begin
      held_q <= {reference_sel, channel_sel, 4'hA};
    end
  end
  assign result_in = held_q;
  // Flag level falls before the next event may count
  assign trigger_in = trig_lvl;
endmodule

// [analog_conversion_sequencer_bench.sv]
`timescale 1ns/1ps
module analog_conversion_sequencer_bench;
  localparam logic [7:0] A_CA = acs_pkg::OFF_CTRL_A;
  localparam logic [7:0] A_CB = acs_pkg::OFF_CTRL_B;
  localparam logic [7:0] A_IS = acs_pkg::OFF_INPUT_SEL;
  localparam logic [7:0] A_RL = acs_pkg::OFF_RESULT_LOW;
  localparam logic [7:0] A_RH = acs_pkg::OFF_RESULT_HIGH;
  localparam logic [7:0] A_ST = acs_pkg::OFF_STATUS;
  localparam logic [1:0] OK   = acs_pkg::RESP_OKAY;
  // Divider select 2 gives 2 clocks per converter half cycle
  localparam int         HC   = 2;

  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, trig_lvl = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF, channel_sel;
  logic [1:0]  s_axi_bresp, s_axi_rresp, reference_sel;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, adc_clk, analog_enable, sample_hold, conv_active;
  logic        adc_q;
  logic [7:0]  trigger_in;
  logic [9:0]  result_in;
  logic [31:0] v;
  logic [1:0]  r;
  int          err_count, n_compared, act_cnt, last_len, last_sh, n_done;
  int          rise_gap, last_gap, cyc, p;

  acs_sequencer dut_u (.aclk, .aresetn, .ce(1'b1), .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .trigger_in, .result_in, .adc_clk, .analog_enable,
    .channel_sel, .reference_sel, .sample_hold, .conv_active);
  acs_analog_model model_u (.aclk, .analog_enable, .channel_sel,
    .reference_sel, .sample_hold, .result_in, .trig_lvl, .trigger_in);

  initial begin
    forever #20 aclk = ~aclk;
  end

  // Conversion length, sample offset and converter clock period in clocks
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    adc_q <= adc_clk;
    rise_gap <= (adc_clk && !adc_q) ? 1 : rise_gap + 1;
    if (adc_clk && !adc_q) begin
      last_gap <= rise_gap;
    end
    if (aresetn) begin
      act_cnt <= conv_active ? act_cnt + 1 : 0;
      if (!conv_active && act_cnt != 0) begin
        last_len <= act_cnt;
        n_done <= n_done + 1;
      end
      if (sample_hold) begin
        last_sh <= act_cnt;
      end
    end
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end

  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
    cmp({30'h0, got}, {30'h0, exp});
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Both channels offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    // Ready stays high so a next call never drives it twice in one step
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    cmp_resp(s_axi_bresp, er);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] rs);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    rs = s_axi_rresp;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  rs;
    rd(a, d, rs);
    cmp(d & m, e);
  endtask

  task automatic poll_done;
    logic [31:0] d;
    logic [1:0]  rs;
    d = 32'h0;
    while (d[3] !== 1'b1) rd(A_CA, d, rs);
  endtask

  task automatic chk_res(input logic [3:0] c, input logic [1:0] f);
    logic [9:0] e;
    e = {f, c, 4'hA};
    rdc(A_RL, 32'hFF, {24'h0, e[7:0]});
    rdc(A_RH, 32'h3, {30'h0, e[9:8]});
  endtask

  task automatic wait_done(input int prev);
    while (n_done == prev) @(posedge aclk);
  endtask

  initial begin
    tick(12);
    aresetn <= 1'b1;
    tick(1);
    rdc(A_CA, 32'hFF, 32'h00);
    rdc(A_CB, 32'h0F, 32'h08);
    rdc(A_ST, 32'h1FF, 32'h02);
    rd(8'h18, v, r);
    cmp_resp(r, acs_pkg::RESP_SLVERR);
    wr(8'h18, 32'h1, acs_pkg::RESP_SLVERR);
    wr(A_IS, 32'h15, OK);
    cmp({26'h0, reference_sel, channel_sel}, 32'h00);
    $display("reset and map test done");
    // Power gate still set: enable and go must do nothing
    wr(A_CA, 32'h23, OK);
    tick(40);
    cmp(n_done, 0);
    cmp({31'h0, analog_enable}, 32'h0);
    cmp({26'h0, reference_sel, channel_sel}, 32'h00);
    wr(A_CB, 32'h00, OK);
    for (int s = 1; s < 8; s++) begin
      wr(A_CA, 32'(1 | (s << 4)), OK);
      tick(4 << s);
      cmp(last_gap, 1 << s);
    end
    cmp(n_done, 0);
    cmp({31'h0, analog_enable}, 32'h1);
    cmp({26'h0, reference_sel, channel_sel}, 32'h15);
    $display("prescaler test done");
    p = n_done;
    wr(A_CA, 32'h23, OK);
    tick(10);
    rdc(A_CA, 32'h02, 32'h02);
    wait_done(p);
    cmp(last_len, 50 * HC);
    cmp(last_sh, 27 * HC);
    rdc(A_CA, 32'h0A, 32'h08);
    chk_res(4'h5, 2'h1);
    p = n_done;
    wr(A_CA, 32'h23, OK);
    tick(4 * HC);
    wr(A_IS, 32'h19, OK);
    cmp({28'h0, channel_sel}, 32'h5);
    wait_done(p);
    cmp(last_len, 26 * HC);
    cmp(last_sh, 3 * HC);
    chk_res(4'h5, 2'h1);
    cmp({26'h0, reference_sel, channel_sel}, 32'h19);
    $display("single conversion test done");
    wr(A_IS, 32'h29, OK);
    wr(A_CA, 32'h29, OK);
    rdc(A_RL, 32'hFF, 32'h5A);
    p = n_done;
    wr(A_CA, 32'h23, OK);
    wait_done(p);
    rdc(A_CA, 32'h08, 32'h08);
    rdc(A_ST, 32'h100, 32'h100);
    rdc(A_RH, 32'h3, 32'h1);
    rdc(A_ST, 32'h100, 32'h000);
    $display("result lock test done");
    wr(A_CB, 32'h02, OK);
    wr(A_CA, 32'h25, OK);
    p = n_done;
    trig_lvl <= 8'h04;
    wait_done(p);
    cmp(last_len, int'(acs_pkg::LEN_AUTO_HALF) * HC);
    cmp(last_sh, int'(acs_pkg::SH_AUTO_HALF) * HC);
    tick(150);
    cmp(n_done, p + 1);
    trig_lvl <= 8'h00;
    tick(10);
    p = n_done;
    trig_lvl <= 8'h04;
    while (conv_active !== 1'b1) @(posedge aclk);
    tick(10);
    trig_lvl <= 8'h00;
    tick(4);
    trig_lvl <= 8'h04;
    wait_done(p);
    tick(150);
    cmp(n_done, p + 1);
    trig_lvl <= 8'h00;
    p = n_done;
    wr(A_CA, 32'h27, OK);
    wait_done(p);
    tick(100);
    cmp(n_done, p + 1);
    $display("auto trigger test done");
    wr(A_CB, 32'h00, OK);
    wr(A_CA, 32'h29, OK);
    wr(A_IS, 32'h03, OK);
    wr(A_CA, 32'h27, OK);
    poll_done();
    wr(A_IS, 32'h0C, OK);
    rdc(A_CA, 32'h02, 32'h02);
    wr(A_CA, 32'h2D, OK);
    poll_done();
    chk_res(4'h3, 2'h0);
    wr(A_CA, 32'h2D, OK);
    poll_done();
    chk_res(4'hC, 2'h0);
    $display("free running test done");
    wr(A_CA, 32'h20, OK);
    tick(3);
    cmp({31'h0, conv_active}, 32'h0);
    cmp({31'h0, analog_enable}, 32'h0);
    tick(40);
    cmp(32'(rise_gap > 40), 32'h1);
    rdc(A_ST, 32'h03, 32'h02);
    $display("disable test done");
    stop_test();
  end
endmodule
